// [rtl/swm_pkg.sv]
// Shared constants and carrier types of the servo warning monitor.
// Assumes a 32-bit classic Wishbone slave port and a single 25 MHz clock.
package swm_pkg;

	// ************************************************************
	// Register map, byte addresses
	// ************************************************************
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_ERR_LVL    = 8'h04;
	localparam logic [7:0] OFS_ERR_PCT    = 8'h08;
	localparam logic [7:0] OFS_SON_LVL    = 8'h0c;
	localparam logic [7:0] OFS_SON_PCT    = 8'h10;
	localparam logic [7:0] OFS_PRE_PCT    = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;
	localparam logic [7:0] OFS_CODE       = 8'h1c;

	// ************************************************************
	// Control field positions and reset values
	// ************************************************************
	localparam int unsigned CTRL_CODE_OUT = 0;
	localparam int unsigned CTRL_NO_WARN  = 1;
	localparam int unsigned CTRL_VIB_WARN = 2;
	localparam logic [2:0]  CTRL_RST      = 3'h0;
	localparam logic [31:0] ERR_LVL_RST   = 32'h0000_1000;
	localparam logic [7:0]  ERR_PCT_RST   = 8'h64;
	localparam logic [31:0] SON_LVL_RST   = 32'h0000_1000;
	localparam logic [7:0]  SON_PCT_RST   = 8'h64;
	localparam logic [7:0]  PRE_PCT_RST   = 8'h50;
	localparam int unsigned PCT_DIV       = 100;

	// ************************************************************
	// Warning bit positions, numeric order of the codes
	// ************************************************************
	localparam int unsigned NW      = 18;
	localparam int unsigned W_ERR   = 0;
	localparam int unsigned W_SON   = 1;
	localparam int unsigned W_OL    = 2;
	localparam int unsigned W_VIB   = 3;
	localparam int unsigned W_REG   = 4;
	localparam int unsigned W_DB    = 5;
	localparam int unsigned W_PNUM  = 6;
	localparam int unsigned W_RANGE = 7;
	localparam int unsigned W_PDATA = 8;
	localparam int unsigned W_SIZE  = 9;
	localparam int unsigned W_LMODE = 10;
	localparam int unsigned W_NCOND = 11;
	localparam int unsigned W_REF   = 12;
	localparam int unsigned W_LBUSY = 13;
	localparam int unsigned W_COMBO = 14;
	localparam int unsigned W_CMD   = 15;
	localparam int unsigned W_COMM  = 16;
	localparam int unsigned W_UV    = 17;

	// Displayed code of each warning bit
	localparam logic [11:0] CODE_TAB [NW] = '{
		12'h900, 12'h901, 12'h910, 12'h911, 12'h920, 12'h921,
		12'h94a, 12'h94b, 12'h94c, 12'h94d, 12'h94e, 12'h95a,
		12'h95b, 12'h95d, 12'h95e, 12'h95f, 12'h960, 12'h971};

	// ************************************************************
	// Carrier types
	// ************************************************************
	// One protection channel: present load and its alarm level
	typedef struct packed {
		logic [15:0] load;
		logic [15:0] alarm_level;
	} swm_load_t;

	// Option-module interface checks, one-cycle pulses
	typedef struct packed {
		logic param_num_bad;
		logic data_range_bad;
		logic param_data_bad;
		logic size_bad;
		logic latch_mode_bad;
		logic op_cmd;
		logic ref_out_bad;
		logic latch_cmd;
		logic bad_combo;
		logic cmd_bad;
		logic comm_fail;
	} swm_hostev_t;

endpackage

// [rtl/swm_thresh.sv]
// Threshold comparator: value against level * percent / 100.
// Assumes level and percent are static while compared; result one clock late.
`timescale 1ns/1ns
module swm_thresh #(
	parameter int unsigned W = 32
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] value_i,
	input  wire logic [W-1:0] level_i,
	input  wire logic [7:0]   pct_i,
	output logic              over_o
);

	// ************************************************************
	// Scaled limit
	// ************************************************************
	// Full product kept so large levels do not wrap
	wire logic [W+7:0] prod  = level_i * pct_i;
	wire logic [W+7:0] limit = prod / (W+8)'(swm_pkg::PCT_DIV);
	wire logic         gt    = {8'h00, value_i} > limit;

	// Registered so the wide divider sees a full cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			over_o <= 1'b0;
		end else begin
			over_o <= gt;
		end
	end

endmodule // swm_thresh

// [rtl/swm_top.sv]
// Warning detection and coding of a linear servo drive, Wishbone slave.
// Assumes alarm detectors supply loads, levels and event pulses in sync.
//
// Behaviour
// R1: Warn 900 when position error exceeds alarm level times percent over 100.
// R2: At motor power on, warn 901 if error exceeds servo-on scaled level.
// R3: Overload warning 910 raised before overload alarms 710 or 720.
// R4: Vibration at the 520 level gives alarm or warning 911 per selector.
// R5: Regenerative overload warning 920 raised before alarm 320.
// R6: Dynamic brake overload warning 921 raised before alarm 731.
// R7: Undervoltage warning 971 raised before alarm 410.
// R8: Invalid received parameter number raises 94A; sender must send valid ones.
// R9: Out-of-range received data raises 94B; sender must stay in range.
// R10: Erroneous received parameter data raises 94C.
// R11: Wrong data size raises 94D; sender must use the correct size.
// R12: Erroneous latch mode settings raise 94E.
// R13: Operating command with conditions unmet raises 95A; sender should wait.
// R14: Faulty reference output from the option module raises 95B.
// R15: Latch command during a latch operation raises 95D; no overlap allowed.
// R16: Disallowed command combination raises 95E; module must avoid it.
// R17: Erroneous command from the option module raises 95F.
// R18: Communication fault with the option module raises 960.
// R19: Warning codes appear on the code outputs only with code selector 1.
// R20: With the detect selector at 1 no warning is detected.
// R21: Warnings never stop operation; alarms follow only their own criteria.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module swm_top (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	// Position loop
	input  wire logic [31:0]         pos_err_i,
	input  wire logic                power_on_i,
	// Protection channels
	input  wire swm_pkg::swm_load_t  overload_i,
	input  wire swm_pkg::swm_load_t  regen_i,
	input  wire swm_pkg::swm_load_t  brake_i,
	input  wire swm_pkg::swm_load_t  undervolt_i,
	input  wire logic                vib_detect_i,
	// Option module interface checks
	input  wire swm_pkg::swm_hostev_t host_ev_i,
	input  wire logic                exec_ok_i,
	input  wire logic                latch_busy_i,
	// Results
	output logic                     vib_alarm_o,
	output logic                     warn_active_o,
	output logic [11:0]              warn_code_o
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic [2:0]             ctrl;
	logic [31:0]            err_lvl;
	logic [7:0]             err_pct;
	logic [31:0]            son_lvl;
	logic [7:0]             son_pct;
	logic [7:0]             pre_pct;
	logic [swm_pkg::NW-1:0] sticky;
	logic [swm_pkg::NW-1:0] next_sticky;
	logic                   power_q;
	logic [11:0]            next_code;

	// ************************************************************
	// Bus decode
	// ************************************************************
	// Request seen, and the edge at which the master takes the answer
	wire logic req      = wb_cyc_i & wb_stb_i;
	wire logic wr_take  = req & wb_we_i & wb_ack_o;
	wire logic lane0    = wb_sel_i[0];
	wire logic all_lane = &wb_sel_i;
	wire logic sel_ctrl = wb_adr_i == swm_pkg::OFS_CTRL;
	wire logic sel_elvl = wb_adr_i == swm_pkg::OFS_ERR_LVL;
	wire logic sel_epct = wb_adr_i == swm_pkg::OFS_ERR_PCT;
	wire logic sel_slvl = wb_adr_i == swm_pkg::OFS_SON_LVL;
	wire logic sel_spct = wb_adr_i == swm_pkg::OFS_SON_PCT;
	wire logic sel_ppct = wb_adr_i == swm_pkg::OFS_PRE_PCT;
	wire logic sel_stat = wb_adr_i == swm_pkg::OFS_STATUS;
	wire logic sel_code = wb_adr_i == swm_pkg::OFS_CODE;

	// Control fields
	wire logic code_output_selector      = ctrl[swm_pkg::CTRL_CODE_OUT];
	wire logic warning_detect_selector   = ctrl[swm_pkg::CTRL_NO_WARN];
	wire logic vibration_detect_selector = ctrl[swm_pkg::CTRL_VIB_WARN];

	// Read mux, unmapped addresses read zero
	wire logic [31:0] rd_mux =
		sel_ctrl ? {29'h0, ctrl} :
		sel_elvl ? err_lvl :
		sel_epct ? {24'h0, err_pct} :
		sel_slvl ? son_lvl :
		sel_spct ? {24'h0, son_pct} :
		sel_ppct ? {24'h0, pre_pct} :
		sel_stat ? {14'h0, sticky} :
		sel_code ? {20'h0, warn_code_o} :
		32'h0;

	// Status clear mask, write one to clear
	wire logic [swm_pkg::NW-1:0] clr =
		(wr_take & sel_stat) ? wb_dat_i[swm_pkg::NW-1:0] : '0;

	// ************************************************************
	// Wishbone answer
	// ************************************************************
	// Fixed one-cycle wait; ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Narrow fields take lane 0; wide levels need all four lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl    <= swm_pkg::CTRL_RST;
			err_pct <= swm_pkg::ERR_PCT_RST;
			son_pct <= swm_pkg::SON_PCT_RST;
			pre_pct <= swm_pkg::PRE_PCT_RST;
		end else if (wr_take & lane0) begin
			if (sel_ctrl) ctrl <= wb_dat_i[2:0];
			if (sel_epct) err_pct <= wb_dat_i[7:0];
			if (sel_spct) son_pct <= wb_dat_i[7:0];
			if (sel_ppct) pre_pct <= wb_dat_i[7:0];
		end
	end

	// Alarm levels, a partial write would leave a torn threshold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_lvl <= swm_pkg::ERR_LVL_RST;
			son_lvl <= swm_pkg::SON_LVL_RST;
		end else if (wr_take & all_lane) begin
			if (sel_elvl) err_lvl <= wb_dat_i;
			if (sel_slvl) son_lvl <= wb_dat_i;
		end
	end

	// ************************************************************
	// Position error thresholds
	// ************************************************************
	logic err_over;
	logic son_over;

	swm_thresh #(.W(32)) u_err_thr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.value_i (pos_err_i),
		.level_i (err_lvl),
		.pct_i   (err_pct),
		.over_o  (err_over)
	);

	swm_thresh #(.W(32)) u_son_thr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.value_i (pos_err_i),
		.level_i (son_lvl),
		.pct_i   (son_pct),
		.over_o  (son_over)
	);

	// Delayed power level, aligned with the registered compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_q <= 1'b0;
		end else begin
			power_q <= power_on_i;
		end
	end

	// Servo-on check looks only in the cycle power comes up
	wire logic power_rise = power_on_i & ~power_q;
	logic      son_check;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			son_check <= 1'b0;
		end else begin
			son_check <= power_rise;
		end
	end

	// ************************************************************
	// Pre-alarm channels
	// ************************************************************
	// Warning fires at a fraction of each alarm level, so it leads the alarm
	swm_pkg::swm_load_t ch [4];
	logic [3:0]         ch_over;

	assign ch[0] = overload_i;
	assign ch[1] = regen_i;
	assign ch[2] = brake_i;
	assign ch[3] = undervolt_i;

	for (genvar g = 0; g < 4; g++) begin : g_pre
		swm_thresh #(.W(16)) u_pre_thr (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.value_i (ch[g].load),
			.level_i (ch[g].alarm_level),
			.pct_i   (pre_pct),
			.over_o  (ch_over[g])
		);
	end

	// ************************************************************
	// Vibration routing
	// ************************************************************
	// Same detection level either way; selector picks the outcome
	wire logic vib_warn  = vib_detect_i & vibration_detect_selector; // R4
	wire logic vib_alarm = vib_detect_i & ~vibration_detect_selector; // R4

	// Alarm path is sticky until reset; the warning path never escalates
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vib_alarm_o <= 1'b0;
		end else if (vib_alarm) begin
			vib_alarm_o <= 1'b1; // R21
		end
	end

	// ************************************************************
	// Option module checks
	// ************************************************************
	wire swm_pkg::swm_hostev_t ev = host_ev_i;
	wire logic cmd_no_cond = ev.op_cmd & ~exec_ok_i; // R13
	wire logic latch_dup   = ev.latch_cmd & latch_busy_i; // R15

	// ************************************************************
	// Raw warning events
	// ************************************************************
	logic [swm_pkg::NW-1:0] raw;

	always_comb begin
		raw                   = '0;
		raw[swm_pkg::W_ERR]   = err_over; // R1
		raw[swm_pkg::W_SON]   = son_check & son_over; // R2
		raw[swm_pkg::W_OL]    = ch_over[0]; // R3
		raw[swm_pkg::W_VIB]   = vib_warn; // R4
		raw[swm_pkg::W_REG]   = ch_over[1]; // R5
		raw[swm_pkg::W_DB]    = ch_over[2]; // R6
		raw[swm_pkg::W_UV]    = ch_over[3]; // R7
		raw[swm_pkg::W_PNUM]  = ev.param_num_bad; // R8
		raw[swm_pkg::W_RANGE] = ev.data_range_bad; // R9
		raw[swm_pkg::W_PDATA] = ev.param_data_bad; // R10
		raw[swm_pkg::W_SIZE]  = ev.size_bad; // R11
		raw[swm_pkg::W_LMODE] = ev.latch_mode_bad; // R12
		raw[swm_pkg::W_NCOND] = cmd_no_cond; // R13
		raw[swm_pkg::W_REF]   = ev.ref_out_bad; // R14
		raw[swm_pkg::W_LBUSY] = latch_dup; // R15
		raw[swm_pkg::W_COMBO] = ev.bad_combo; // R16
		raw[swm_pkg::W_CMD]   = ev.cmd_bad; // R17
		raw[swm_pkg::W_COMM]  = ev.comm_fail; // R18
	end

	// Detection switched off masks every source at once
	wire logic [swm_pkg::NW-1:0] set =
		warning_detect_selector ? '0 : raw; // R20

	// ************************************************************
	// Sticky status
	// ************************************************************
	// Set wins over a clear in the same cycle, so no event is lost
	assign next_sticky = (sticky & ~clr) | set;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sticky <= '0;
		end else begin
			sticky <= next_sticky;
		end
	end

	// ************************************************************
	// Code selection
	// ************************************************************
	// Lowest-numbered active warning is shown; nothing is gated by it
	always_comb begin
		next_code = 12'h000;
		for (int i = swm_pkg::NW - 1; i >= 0; i--) begin
			if (sticky[i]) begin
				next_code = swm_pkg::CODE_TAB[i];
			end
		end
		if (!code_output_selector) begin
			next_code = 12'h000; // R19
		end
	end

	// Outputs are flags only; the drive keeps running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			warn_code_o   <= 12'h000;
			warn_active_o <= 1'b0;
		end else begin
			warn_code_o   <= next_code;
			warn_active_o <= |sticky; // R21
		end
	end

endmodule // swm_top

// [test/swm_top_monitor.sv]
// Port checker of the warning monitor, bound onto swm_top.
// Assumes one clock; CTRL is shadowed from the Wishbone writes it sees.
`timescale 1ns/1ns
module swm_top_monitor (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic                 wb_ack_o,
	input  wire swm_pkg::swm_hostev_t host_ev_i,
	input  wire logic                 exec_ok_i,
	input  wire logic                 latch_busy_i,
	input  wire logic                 vib_detect_i,
	input  wire logic                 vib_alarm_o,
	input  wire logic                 warn_active_o,
	input  wire logic [11:0]          warn_code_o
);
	// ****************************************
	// Helper logic and assertions
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0]  ctrl;
	logic [2:0]  nd_cnt;
	logic [10:0] ev_raw;
	assign ev_raw = host_ev_i;
	// Op and latch commands warn only under their bad condition
	wire ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == swm_pkg::OFS_CTRL && wb_sel_i[0];
	wire req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire evt     = (|(ev_raw & 11'h7d7)) || (host_ev_i.op_cmd && !exec_ok_i)
		|| (host_ev_i.latch_cmd && latch_busy_i) || (vib_detect_i && ctrl[2]);
	// Shadow CTRL; count edges with detection off, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl   <= 3'h0;
			nd_cnt <= 3'h0;
		end else begin
			ctrl   <= ctrl_wr ? wb_dat_i[2:0] : ctrl;
			nd_cnt <= !ctrl[1] ? 3'h0 : nd_cnt + {2'h0, nd_cnt != 3'h7};
		end
	end
	a_ack_one_wait: assert property (req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
	a_event_warns: assert property (evt && !ctrl[1] |-> ##2 warn_active_o)
		else $error("event gave no warning");
	a_no_detect: assert property (nd_cnt >= 3'h4 && !warn_active_o |=> !warn_active_o)
		else $error("warning while detection off");
	a_code_gated: assert property (!ctrl[0] && $past(!ctrl[0]) |-> warn_code_o == 12'h0)
		else $error("code shown while output off");
	a_code_active: assert property (warn_code_o != 12'h0 |-> warn_active_o)
		else $error("code without warning");
	a_vib_alarm: assert property (vib_detect_i && ctrl[2:1] == 2'h0 |-> ##[1:2] vib_alarm_o)
		else $error("vibration alarm missing");
	a_vib_sticky: assert property (vib_alarm_o |=> vib_alarm_o) else $error("alarm dropped");
	c_event: cover property (evt ##2 warn_active_o);
	c_vib: cover property ($rose(vib_alarm_o));
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // swm_top_monitor

// [test/swm_opt_model.sv]
// Model of the option module and host controller feeding interface events.
// Assumes its task is called right after a rising clock edge.
`timescale 1ns/1ns
module swm_opt_model (
	input  wire logic            clk_i,
	output swm_pkg::swm_hostev_t host_ev_o,
	output logic                 exec_ok_o,
	output logic                 latch_busy_o
);
	// ****************************************
	// Transfer driver
	// ****************************************
	initial begin
		host_ev_o    = '0;
		exec_ok_o    = 1'b1;
		latch_busy_o = 1'b0;
	end
	// One transfer of field j; bad=0 keeps every sender rule, so only
	// commanded faults ever reach the device
	task automatic send(input int j, input logic bad);
		exec_ok_o    <= !(bad && j == 5);
		latch_busy_o <= bad && j == 7;
		host_ev_o    <= (bad || j == 5 || j == 7) ? 11'h400 >> j : 11'h0;
		@(posedge clk_i);
		host_ev_o    <= '0;
		exec_ok_o    <= 1'b1;
		latch_busy_o <= 1'b0;
	endtask
endmodule // swm_opt_model

// [test/swm_top_bench.sv]
// Self-checking bench of the servo warning monitor.
// Assumes swm_pkg, swm_top and the option-module model are compiled first.
`timescale 1ns/1ns
module swm_top_bench;
	// ****************************************
	// Stimulus, expectations and checks
	// ****************************************
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic                 wb_cyc_i = 1'b0;
	logic                 wb_stb_i = 1'b0;
	logic                 wb_we_i = 1'b0;
	logic [7:0]           wb_adr_i = 8'h00;
	logic [31:0]          wb_dat_i = 32'h0;
	logic [3:0]           wb_sel_i = 4'hf;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	logic [31:0]          pos_err_i = 32'h0;
	logic                 power_on_i = 1'b0;
	swm_pkg::swm_load_t   ch [4] = '{default: '0};
	logic                 vib_detect_i = 1'b0;
	swm_pkg::swm_hostev_t host_ev;
	logic                 exec_ok;
	logic                 latch_busy;
	logic                 vib_alarm_o;
	logic                 warn_active_o;
	logic [11:0]          warn_code_o;
	logic [31:0]          seed = 32'h1b59;
	logic [31:0]          q;
	logic [31:0]          lvl;
	logic [7:0]           pct;
	int                   bad_count = 0;
	int                   checked = 0;
	int                   cyc = 0;
	logic [11:0] hcode [11] = '{12'h94a, 12'h94b, 12'h94c, 12'h94d, 12'h94e, 12'h95a,
		12'h95b, 12'h95d, 12'h95e, 12'h95f, 12'h960};
	logic [11:0] kcode [6] = '{12'h900, 12'h901, 12'h910, 12'h920, 12'h921, 12'h971};
	logic [7:0]  rofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	logic [31:0] rval [9] = '{32'h0, 32'h1000, 32'h64, 32'h1000, 32'h64, 32'h50, 0, 0, 0};

	swm_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pos_err_i, .power_on_i,
		.overload_i(ch[0]), .regen_i(ch[1]), .brake_i(ch[2]), .undervolt_i(ch[3]),
		.vib_detect_i, .host_ev_i(host_ev), .exec_ok_i(exec_ok),
		.latch_busy_i(latch_busy), .vib_alarm_o, .warn_active_o, .warn_code_o);
	swm_opt_model u_opt (.clk_i, .host_ev_o(host_ev), .exec_ok_o(exec_ok),
		.latch_busy_o(latch_busy));

	// Free-running clock and hang guard
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Floor of level times percent over one hundred
	function automatic logic [31:0] thr(input logic [31:0] l, input logic [7:0] p);
		return (l * p) / 32'd100;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Values are seen as sampled at the edge, before its updates land
	// Byte lanes default to a full word; partial lanes probe the refused writes
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		chk(n < 20, 1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Settle, compare, then drop the causes before clearing, or they re-arm
	task automatic expect_code(input logic [11:0] e, input logic act);
		repeat (5) @(posedge clk_i);
		chk(warn_code_o, e);
		chk(warn_active_o, act);
		wb(1'b0, swm_pkg::OFS_CODE, 32'h0);
		chk(q, {20'h0, e});
		pos_err_i  <= 32'h0;
		power_on_i <= 1'b0;
		ch         <= '{default: '0};
		repeat (3) @(posedge clk_i);
		wb(1'b1, swm_pkg::OFS_STATUS, 32'hffff_ffff);
	endtask
	task automatic drive(input int k, input logic [31:0] v, input logic [15:0] al);
		if (k < 2) begin
			pos_err_i  <= v;
			power_on_i <= k == 1;
		end else begin
			ch[k-2] <= '{load: v[15:0], alarm_level: al};
		end
	endtask
	task automatic results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, rofs[i], 32'h0);
			chk(q, rval[i]);
		end
		$display("reset values done");
		// Level needs all lanes, byte fields need lane 0; both writes must be ignored
		wb(1'b1, swm_pkg::OFS_ERR_LVL, 32'h0000_1234, 4'h7);
		wb(1'b1, swm_pkg::OFS_PRE_PCT, 32'h0000_0011, 4'he);
		wb(1'b0, swm_pkg::OFS_ERR_LVL, 32'h0);
		chk(q, swm_pkg::ERR_LVL_RST);
		wb(1'b0, swm_pkg::OFS_PRE_PCT, 32'h0);
		chk(q, {24'h0, swm_pkg::PRE_PCT_RST});
		$display("lane checks done");
		wb(1'b1, swm_pkg::OFS_CTRL, 32'h1);
		for (int j = 0; j < 11; j++) begin
			u_opt.send(j, 1'b1);
			wb(1'b0, swm_pkg::OFS_STATUS, 32'h0);
			chk(q, 32'h1 << (swm_pkg::W_PNUM + j));
			expect_code(hcode[j], 1'b1);
		end
		u_opt.send(5, 1'b0);
		expect_code(12'h0, 1'b0);
		u_opt.send(7, 1'b0);
		expect_code(12'h0, 1'b0);
		$display("interface events done");
		for (int k = 0; k < 6; k++) begin
			if (k == 1) wb(1'b1, swm_pkg::OFS_ERR_LVL, 32'h00ff_ffff);
			for (int i = 0; i < 3; i++) begin
				lvl = (i == 0) ? 32'h7fff : rnd() & 32'h7fff;
				pct = (i == 0) ? 8'h64 : 8'(rnd() % 100 + 1);
				if (k < 2) wb(1'b1, k ? swm_pkg::OFS_SON_LVL : swm_pkg::OFS_ERR_LVL, lvl);
				wb(1'b1, k > 1 ? swm_pkg::OFS_PRE_PCT : k ? swm_pkg::OFS_SON_PCT
					: swm_pkg::OFS_ERR_PCT, {24'h0, pct});
				drive(k, thr(lvl, pct), lvl[15:0]);
				expect_code(12'h0, 1'b0);
				drive(k, thr(lvl, pct) + 32'h1, lvl[15:0]);
				expect_code(kcode[k], 1'b1);
			end
		end
		$display("thresholds done");
		wb(1'b1, swm_pkg::OFS_CTRL, 32'h5);
		vib_detect_i <= 1'b1;
		@(posedge clk_i);
		vib_detect_i <= 1'b0;
		expect_code(12'h911, 1'b1);
		chk(vib_alarm_o, 0);
		wb(1'b1, swm_pkg::OFS_CTRL, 32'h3);
		repeat (2) @(posedge clk_i);
		u_opt.send(0, 1'b1);
		expect_code(12'h0, 1'b0);
		wb(1'b1, swm_pkg::OFS_CTRL, 32'h0);
		u_opt.send(3, 1'b1);
		expect_code(12'h0, 1'b1);
		vib_detect_i <= 1'b1;
		@(posedge clk_i);
		vib_detect_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(vib_alarm_o, 1);
		chk(warn_active_o, 0);
		$display("selectors done");
		results();
	end
endmodule // swm_top_bench

bind swm_top swm_top_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .host_ev_i, .exec_ok_i, .latch_busy_i,
	.vib_detect_i, .vib_alarm_o, .warn_active_o, .warn_code_o);
